/* File: core/lsm_led_mux.sv */
// LED status output multiplexer for six shared general purpose pins.
//
// Notes on behaviour
// - Each of pins 5..0 becomes an LED when its own enable bit is set.
// - LED pins drive push-pull or open-drain; input buffer and pull-up off.
// - Enable, function code and polarity load from straps at reset.
// - A 3-bit function code picks the pin map for all six LEDs; port1_phy_enable changes only pins 2..0.
// - The global disable turns every LED off regardless of enable or code.
// - When disabled, open-drain pins float and push-pull pins drive inactive.
// - Code 000: link/activity, duplex/collision and speed per port.
// - Code 001: fast and slow link/activity plus duplex/collision per port.
// - Code 010: transmit and receive pulses, link/activity and speed.
// - Code 011: activity, link and speed, with split mapping.
// - Active drives the inverse of the strap level; polarity is fixed.
// - Activity pulses on for 80 ms, then off 80 ms; held off without link on an internal PHY port.
// - Link/activity is on with link and blinks off 80 ms on traffic.
// - Duplex/collision on in full duplex; half duplex pulses on collisions.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_params.svh"
module lsm_led_mux
  import lsm_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = `LSM_PULSE_MS * `LSM_CLK_KHZ,
  parameter int unsigned CNT_W        = `LSM_CNT_W
) (
  input  wire logic [5:0] led_enable_default_strap,
  input  wire logic [2:0] led_function_default_strap,
  input  wire logic [5:0] led_polarity_strap,
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cfg_write,
  input  wire logic [5:0] cfg_pin_enable,
  input  wire logic [2:0] cfg_function_code,
  input  wire logic       led_global_disable,
  input  wire logic [5:0] led_push_pull,
  input  wire logic       port1_phy_enable,
  input  wire logic [2:0] port_internal_phy,
  input  wire logic [2:0] port_link,
  input  wire logic [2:0] port_speed100,
  input  wire logic [2:0] port_full_duplex,
  input  wire logic [2:0] port_collision,
  input  wire logic [2:0] port_tx_activity,
  input  wire logic [2:0] port_rx_activity,
  output logic      [5:0] led_pin_enable,
  output logic      [2:0] led_function_code,
  output logic      [5:0] led_polarity,
  output logic      [5:0] led_out,
  output logic      [5:0] led_oe_n,
  output logic      [5:0] gpio_input_enable,
  output logic      [5:0] gpio_pullup_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration. Straps are caught on the first edge after reset release,
  // because an asynchronous reset may only load constants.

  logic strap_taken;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_pin_enable    <= `LSM_EN_RST;
      led_function_code <= `LSM_FUN_RST;
    end else if (!strap_taken) begin
      led_pin_enable    <= led_enable_default_strap;
      led_function_code <= led_function_default_strap;
    end else if (cfg_write) begin
      led_pin_enable    <= cfg_pin_enable;
      led_function_code <= cfg_function_code;
    end
  end

  // Polarity has no soft path, so a later configuration write leaves it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_polarity <= `LSM_POL_RST;
    end else if (!strap_taken) begin
      led_polarity <= led_polarity_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indications, five independent timers per port: activity, link/activity, transmit, receive and collision.

  logic [2:0] act_p;
  logic [2:0] la_p;
  logic [2:0] tx_p;
  logic [2:0] rx_p;
  logic [2:0] col_p;
  logic [2:0] traffic;
  lsm_ind_t   ind;

  assign traffic = port_tx_activity | port_rx_activity;

  for (genvar p = 0; p < `LSM_PORTS; p++) begin : g_port
    lsm_pulse_if act_if ();
    lsm_pulse_if la_if ();
    lsm_pulse_if tx_if ();
    lsm_pulse_if rx_if ();
    lsm_pulse_if col_if ();

    assign act_if.trigger = traffic[p];
    assign act_if.hold    = port_internal_phy[p] & ~port_link[p];
    assign la_if.trigger  = traffic[p];
    assign la_if.hold     = ~port_link[p];
    assign tx_if.trigger  = port_tx_activity[p];
    assign tx_if.hold     = 1'b0;
    assign rx_if.trigger  = port_rx_activity[p];
    assign rx_if.hold     = 1'b0;
    assign col_if.trigger = port_collision[p] & ~port_full_duplex[p];
    assign col_if.hold    = ~port_link[p] | port_full_duplex[p];

    assign act_p[p] = act_if.pulse;
    assign la_p[p]  = la_if.pulse;
    assign tx_p[p]  = tx_if.pulse;
    assign rx_p[p]  = rx_if.pulse;
    assign col_p[p] = col_if.pulse;

    lsm_pulse #(.CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) u_act (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tmr     (act_if.timer)
    );
    lsm_pulse #(.CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) u_la (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tmr     (la_if.timer)
    );
    lsm_pulse #(.CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) u_tx (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tmr     (tx_if.timer)
    );
    lsm_pulse #(.CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) u_rx (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tmr     (rx_if.timer)
    );
    lsm_pulse #(.CYCLES(PULSE_CYCLES), .CNT_W(CNT_W)) u_col (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tmr     (col_if.timer)
    );
  end

  logic [2:0] link_act;

  assign link_act = port_link & ~la_p;

  always_comb begin
    ind.act      = act_p;
    ind.link_act = link_act;
    ind.fast_la  = link_act & port_speed100;
    ind.slow_la  = link_act & ~port_speed100;
    ind.tx       = tx_p;
    ind.rx       = rx_p;
    ind.dup_col  = port_link & (port_full_duplex | col_p);
    ind.speed    = port_link & port_speed100;
    ind.link     = port_link;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin map. Codes 100 to 111 show nothing here.

  function automatic logic [5:0] lsm_pick(
    input logic [2:0] code,
    input logic       phy1,
    input lsm_ind_t   i
  );
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      `LSM_FUN_LNKACT:
        m = {i.link_act[2], i.dup_col[2], i.speed[2],
             phy1 ? i.link_act[1] : i.act[1],
             phy1 ? i.dup_col[1]  : 1'b0,
             phy1 ? i.speed[1]    : i.act[0]};
      `LSM_FUN_SPDACT:
        m = {i.fast_la[2], i.dup_col[2], i.slow_la[2],
             phy1 ? i.fast_la[1] : i.act[1],
             phy1 ? i.dup_col[1] : 1'b0,
             phy1 ? i.slow_la[1] : i.act[0]};
      `LSM_FUN_TXRX:
        m = {i.tx[0], i.link_act[2], i.speed[2], i.rx[0],
             phy1 ? i.link_act[1] : i.tx[1],
             phy1 ? i.speed[1]    : i.rx[1]};
      `LSM_FUN_SPLIT:
        m = {i.act[2], i.link[2], i.speed[2], i.act[1],
             phy1 ? i.link[1]  : i.dup_col[2],
             phy1 ? i.speed[1] : i.act[0]};
      default:
        m = 6'h00;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered.

  logic [5:0] shown;
  logic [5:0] next_led_out;
  logic [5:0] next_led_oe_n;

  assign shown = led_global_disable ? 6'h00 :
                 lsm_pick(led_function_code, port1_phy_enable, ind);

  always_comb begin
    for (int k = 0; k < `LSM_PINS; k++) begin
      next_led_out[k]  = 1'b0;
      next_led_oe_n[k] = 1'b1;
      if (led_pin_enable[k]) begin
        next_led_out[k]  = led_polarity[k] ^ shown[k];
        next_led_oe_n[k] = ~(shown[k] | led_push_pull[k]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_out  <= `LSM_OUT_RST;
      led_oe_n <= `LSM_OE_RST;
    end else begin
      led_out  <= next_led_out;
      led_oe_n <= next_led_oe_n;
    end
  end

  // The shared pin's input path is cut while the LED owns it.
  assign gpio_input_enable  = ~led_pin_enable;
  assign gpio_pullup_enable = ~led_pin_enable;

endmodule
`default_nettype wire

/* File: core/lsm_params.svh */
// Constants for the LED status output multiplexer.
`ifndef LSM_PARAMS_SVH
`define LSM_PARAMS_SVH

`define LSM_PINS        6
`define LSM_PORTS       3
`define LSM_CLK_KHZ     40000
`define LSM_PULSE_MS    80
`define LSM_CNT_W       22
`define LSM_EN_RST      6'h00
`define LSM_FUN_RST     3'h0
`define LSM_POL_RST     6'h00
`define LSM_OUT_RST     6'h00
`define LSM_OE_RST      6'h3F
`define LSM_FUN_LNKACT  3'h0
`define LSM_FUN_SPDACT  3'h1
`define LSM_FUN_TXRX    3'h2
`define LSM_FUN_SPLIT   3'h3

`endif

/* File: core/lsm_pkg.sv */
// Types shared by the LED status output multiplexer.
`default_nettype none
package lsm_pkg;

  typedef enum logic [1:0] {
    LSM_IDLE,
    LSM_ON,
    LSM_OFF
  } lsm_pulse_st_t;

  // One bit per port for each indication kind.
  typedef struct packed {
    logic [2:0] act;
    logic [2:0] link_act;
    logic [2:0] fast_la;
    logic [2:0] slow_la;
    logic [2:0] tx;
    logic [2:0] rx;
    logic [2:0] dup_col;
    logic [2:0] speed;
    logic [2:0] link;
  } lsm_ind_t;

endpackage
`default_nettype wire

/* File: core/lsm_pulse.sv */
// Pulse timer: one fixed-length pulse, then a minimum quiet time.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_params.svh"
module lsm_pulse
  import lsm_pkg::*;
#(
  parameter int unsigned CYCLES = `LSM_PULSE_MS * `LSM_CLK_KHZ,
  parameter int unsigned CNT_W  = `LSM_CNT_W
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  lsm_pulse_if.timer  tmr
);

  lsm_pulse_st_t    state;
  logic [CNT_W-1:0] cnt;
  logic             done;

  assign done      = (cnt == CNT_W'(CYCLES - 1));
  assign tmr.pulse = (state == LSM_ON);

  ////////////////////////////////////////////////////////////////////////////
  // Activity during the quiet time is dropped; the next event restarts it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LSM_IDLE;
    end else if (tmr.hold) begin
      state <= LSM_IDLE;
    end else begin
      unique case (state)
        LSM_IDLE: if (tmr.trigger) state <= LSM_ON;
        LSM_ON:   if (done) state <= LSM_OFF;
        LSM_OFF:  if (done) state <= LSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (tmr.hold || state == LSM_IDLE || done) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

/* File: core/lsm_pulse_if.sv */
// Trigger, hold and pulse signals between an indication and its timer.
`timescale 1ns/1ps
`default_nettype none
interface lsm_pulse_if;
  logic trigger;
  logic hold;
  logic pulse;
  modport timer (input trigger, input hold, output pulse);
  modport user  (output trigger, output hold, input pulse);
endinterface
`default_nettype wire

/* File: dv/lsm_led_model.sv */
// External status LEDs hanging on the six shared pins.
`timescale 1ns/1ps
`default_nettype none
module lsm_led_model (
  input  wire logic [5:0] led_out,
  input  wire logic [5:0] led_oe_n,
  input  wire logic [5:0] strap,
  output logic      [5:0] lit
);
  // A released pin floats to its strap level, so it never lights.
  assign lit = ~led_oe_n & (led_out ^ strap);
endmodule
`default_nettype wire

/* File: dv/lsm_led_mux_chk.sv */
// Assertions on the ports of the LED status output multiplexer.
`timescale 1ns/1ps
`default_nettype none
module lsm_led_mux_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [5:0] led_enable_default_strap,
  input wire logic [2:0] led_function_default_strap,
  input wire logic [5:0] led_polarity_strap,
  input wire logic       cfg_write,
  input wire logic [5:0] cfg_pin_enable,
  input wire logic [2:0] cfg_function_code,
  input wire logic       led_global_disable,
  input wire logic [5:0] led_push_pull,
  input wire logic [2:0] port_link,
  input wire logic [2:0] port_speed100,
  input wire logic [5:0] led_pin_enable,
  input wire logic [2:0] led_function_code,
  input wire logic [5:0] led_polarity,
  input wire logic [5:0] led_out,
  input wire logic [5:0] led_oe_n,
  input wire logic [5:0] gpio_input_enable,
  input wire logic [5:0] gpio_pullup_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  gpio_bufs_a: assert property (
    gpio_input_enable == ~led_pin_enable &&
    gpio_pullup_enable == ~led_pin_enable) else $error("gpio buffer on");
  strap_load_a: assert property ($rose(rst_n) |=>
    led_pin_enable == $past(led_enable_default_strap) &&
    led_function_code == $past(led_function_default_strap) &&
    led_polarity == $past(led_polarity_strap)) else $error("strap load");
  cfg_load_a: assert property (cfg_write && !$rose(rst_n) |=>
    led_pin_enable == $past(cfg_pin_enable) &&
    led_function_code == $past(cfg_function_code)) else $error("cfg load");
  pol_fixed_a: assert property ($past(rst_n, 2) |->
    $stable(led_polarity)) else $error("polarity moved");
  pin_off_a: assert property (1 |=>
    &(led_oe_n | $past(led_pin_enable)) &&
    (led_out & ~$past(led_pin_enable)) == 6'h00) else $error("gpio pin");
  led_global_disable_a: assert property (
    (led_global_disable && !cfg_write)[*3] |=>
    led_out == (led_polarity & led_pin_enable) &&
    (led_oe_n & led_pin_enable) == (led_pin_enable & ~led_push_pull))
    else $error("disable");
  link_map_a: assert property (
    (led_function_code == 3'h3 && led_pin_enable[4] && !led_global_disable
    && $stable(port_link))[*2] |=>
    led_out[4] == (led_polarity[4] ^ $past(port_link[2]))) else $error("link");
  spd_map_a: assert property (
    (led_function_code == 3'h3 && led_pin_enable[3] && !led_global_disable
    && $stable(port_link) && $stable(port_speed100))[*2] |=>
    led_out[3] == (led_polarity[3] ^ $past(port_link[2] & port_speed100[2])))
    else $error("speed");
endmodule
`default_nettype wire

/* File: dv/lsm_led_mux_tb.sv */
// Self-checking bench for the LED status output multiplexer.
`timescale 1ns/1ps
`default_nettype none
module lsm_led_mux_tb;
  localparam int unsigned PC  = 8;
  localparam logic [5:0]  POL = 6'h15;
  localparam logic [5:0]  PP  = 6'h0F;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cfg_write = 1'b0;
  logic       dis = 1'b0;
  logic       phy1 = 1'b1;
  logic [5:0] cfg_en = 6'h00;
  logic [2:0] cfg_fun = 3'h0;
  logic [2:0] link = 3'h7;
  logic [2:0] iphy = 3'h7;
  logic [2:0] spd = 3'h7;
  logic [2:0] fdx = 3'h6;
  logic [2:0] col = 3'h0;
  logic [2:0] tx = 3'h0;
  logic [2:0] rx = 3'h0;
  logic [5:0] en_q, pol_q, out, oe_n, gin, gpu, lit;
  logic [2:0] fun_q;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         n;
  logic [5:0] exp_map [10] = '{6'h38, 6'h3F, 6'h30, 6'h36, 6'h18,
                               6'h1B, 6'h1A, 6'h1B, 6'h00, 6'h00};
  always #12.5 sys_clk = ~sys_clk;
  lsm_led_mux #(.PULSE_CYCLES(PC)) dut (
    .led_enable_default_strap(6'h3F), .led_function_default_strap(3'h3),
    .led_polarity_strap(POL), .sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_write(cfg_write), .cfg_pin_enable(cfg_en),
    .cfg_function_code(cfg_fun), .led_global_disable(dis),
    .led_push_pull(PP), .port1_phy_enable(phy1),
    .port_internal_phy(iphy), .port_link(link), .port_speed100(spd),
    .port_full_duplex(fdx), .port_collision(col),
    .port_tx_activity(tx), .port_rx_activity(rx),
    .led_pin_enable(en_q), .led_function_code(fun_q),
    .led_polarity(pol_q), .led_out(out), .led_oe_n(oe_n),
    .gpio_input_enable(gin), .gpio_pullup_enable(gpu));
  lsm_led_model leds (.led_out(out), .led_oe_n(oe_n), .strap(POL),
    .lit(lit));
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] want);
    num_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic cfg(input logic [5:0] e, input logic [2:0] f);
    @(negedge sys_clk);
    cfg_en = e;
    cfg_fun = f;
    cfg_write = 1'b1;
    @(negedge sys_clk);
    cfg_write = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic kick(input int w);
    @(negedge sys_clk);
    if (w == 0) tx[2] = 1'b1;
    else if (w == 1) rx[2] = 1'b1;
    else col[2] = 1'b1;
    @(negedge sys_clk);
    tx = 3'h0;
    rx = 3'h0;
    col = 3'h0;
  endtask
  // Counts how long one LED keeps a level once it has reached it.
  task automatic span(input int p, input logic v, output int c);
    int t;
    t = 0;
    c = 0;
    while (lit[p] !== v && t < 6) begin
      @(negedge sys_clk);
      t++;
    end
    while (lit[p] === v && c < 40) begin
      @(negedge sys_clk);
      c++;
    end
  endtask
  task automatic t_reset();
    repeat (3) @(negedge sys_clk);
    chk(en_q, 6'h3F);
    chk({3'h0, fun_q}, 6'h03);
    chk(pol_q, POL);
    chk(gin | gpu, 6'h00);
  endtask
  task automatic t_map();
    for (int c = 0; c < 5; c++) begin
      for (int p = 0; p < 2; p++) begin
        phy1 = p[0];
        cfg(6'h3F, c[2:0]);
        chk(lit, exp_map[c * 2 + p]);
        chk(oe_n, ~(exp_map[c * 2 + p] | PP));
      end
    end
  endtask
  task automatic t_pulse();
    cfg(6'h3F, 3'h3);
    kick(0);
    span(5, 1'b1, n);
    chk(6'(n), 6'(PC));
    chk({5'h0, lit[2]}, 6'h00);
    kick(1);
    span(5, 1'b1, n);
    chk(6'(n), 6'h00);
    kick(0);
    span(5, 1'b1, n);
    chk(6'(n), 6'(PC));
    repeat (PC) @(negedge sys_clk);
    kick(1);
    link[2] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(lit, 6'h03);
    // An external PHY keeps activity pulsing even without link.
    iphy[2] = 1'b0;
    kick(0);
    span(5, 1'b1, n);
    chk(6'(n), 6'(PC));
    iphy[2] = 1'b1;
    link[2] = 1'b1;
    repeat (2 * PC) @(negedge sys_clk);
  endtask
  task automatic t_blink();
    cfg(6'h3F, 3'h0);
    kick(0);
    span(5, 1'b0, n);
    chk(6'(n), 6'(PC));
    fdx = 3'h2;
    kick(2);
    span(4, 1'b1, n);
    chk(6'(n), 6'(PC));
    fdx = 3'h6;
  endtask
  task automatic t_dis();
    dis = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(lit, 6'h00);
    chk(oe_n, ~PP);
    chk(out, POL);
    dis = 1'b0;
  endtask
  task automatic t_cfg();
    @(negedge sys_clk);
    cfg_en = 6'h3C;
    cfg_write = 1'b1;
    @(negedge sys_clk);
    cfg_en = 6'h05;
    @(negedge sys_clk);
    cfg_write = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(en_q, 6'h05);
    chk(gin, 6'h3A);
    chk(oe_n | 6'h05, 6'h3F);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_map();
    t_pulse();
    t_blink();
    t_dis();
    t_cfg();
    give_verdict();
  end
endmodule
bind lsm_led_mux lsm_led_mux_chk chk (
  .sys_clk                    (sys_clk),
  .rst_n                      (rst_n),
  .led_enable_default_strap   (led_enable_default_strap),
  .led_function_default_strap (led_function_default_strap),
  .led_polarity_strap         (led_polarity_strap),
  .cfg_write                  (cfg_write),
  .cfg_pin_enable             (cfg_pin_enable),
  .cfg_function_code          (cfg_function_code),
  .led_global_disable         (led_global_disable),
  .led_push_pull              (led_push_pull),
  .port_link                  (port_link),
  .port_speed100              (port_speed100),
  .led_pin_enable             (led_pin_enable),
  .led_function_code          (led_function_code),
  .led_polarity               (led_polarity),
  .led_out                    (led_out),
  .led_oe_n                   (led_oe_n),
  .gpio_input_enable          (gpio_input_enable),
  .gpio_pullup_enable         (gpio_pullup_enable)
);
`default_nettype wire
